// ===== shared/register_readback_status_params.svh
// Constants for the serial register readback and status block.
// Assumes a 24-bit host frame, MSB first, one frame per select-low period.
// Behaviour
// - A frame with its top bit set is a read request, not a write.
// - Read request: bits 22-21 device address, 20-16 selector, low 16 ignored.
// - Next transfer after a read shifts out the register chosen by that read.
// - No-operation word is 0x1CE000 with bits 22-21 set to the address.
// - Selectors 0-3 return data, 4-7 control registers of channels A-D.
// - Selectors 8-11 return gain, 12-15 offset registers of channels A-D.
// - Selectors 16-19 return clear-code, 20-23 slew control of channels A-D.
// - Selector 24 returns status, 25 main control, 26 boost control.
// - For device address 1 the no-operation word is 0x3CE000.
// - Slew word: 15-13 zero, 12 enable, 11-7 ignored, 6-3 rate, 2-0 step.
// - Each channel has its own slew enable and settings.
// - Status is read-only: faults, ramp flag and user toggle.
// - With status echo set, status is shifted out during every frame that does not follow an own read.
// - With status echo clear, status is read only by normal readback.
// - Status bit layout: boost faults, toggle, check error, ramp, temp, faults.
// - User toggle status bit follows the value written by software command.
// - Packet check bit flags a check failure on the last received word.
// - Ramp bit set while a slew-enabled channel is still stepping.
// - Boost fault bits alone never raise the fault pin.
`ifndef REGISTER_READBACK_STATUS_PARAMS_SVH
`define REGISTER_READBACK_STATUS_PARAMS_SVH
`define FRAME_BITS 5'h18
`define FRAME_LAST 5'h17
`define RW_BIT 5'h17
`define ADDR_HI 5'h16
`define ADDR_LO 5'h15
`define SEL_HI 5'h14
`define SEL_LO 5'h10
`define NOP_WORD 24'h1CE000
`define NOP_ADDR_MASK 24'h600000
`define REG_COUNT 27
`define SEL_SLEW_A 5'h14
`define SEL_SLEW_D 5'h17
`define SEL_STATUS 5'h18
`define SEL_MAIN 5'h19
`define SEL_LAST 5'h1A
`define SEL_SOFTWARE 5'h1B
`define SLEW_KEEP_MASK 16'h107F
`define SLEW_EN_BIT 12
`define SLEW_RATE_HI 6
`define SLEW_RATE_LO 3
`define SLEW_STEP_HI 2
`define STATUS_ECHO_BIT 11
`define USER_TOGGLE_CMD_BIT 12
`define TX_PAD 1'h0
`define REG_RESET 16'h0000
`define TX_RESET 24'h000000
`endif

// ===== shared/register_readback_status_pkg.sv
// Types shared by the readback block.
// Constants live in the params header.
package register_readback_status_pkg;
  typedef logic [15:0] reg_word_type;
  typedef enum logic [1:0] {
    FRAME_WRITE,
    FRAME_READ_OWN,
    FRAME_FOREIGN
  } frame_kind_type;
endpackage

// ===== rtl/pin_sync.sv
// Two-stage synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherency across bits.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage_reg;
  logic [WIDTH-1:0] out_reg;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      stage_reg <= '0;
      out_reg <= '0;
    end else begin
      stage_reg <= pinIn;
      out_reg <= stage_reg;
    end
  end

  assign pinOut = out_reg;
endmodule // pin_sync

// ===== rtl/register_readback_status.sv
// Serial register readback and status path of a quad output converter.
// Assumes the host holds frames of 24 link clocks and leaves a gap
// of at least 8 system clocks between frames.
`timescale 1ns/1ps
`include "register_readback_status_params.svh"
module register_readback_status (
  input wire logic clk,
  input wire logic srst,
  input wire logic linkClk,
  input wire logic frameSelectN,
  input wire logic serialIn,
  output logic serialOut,
  input wire logic deviceAddrHigh,
  input wire logic deviceAddrLow,
  input wire logic [3:0] boostFaultIn,
  input wire logic [3:0] voutFaultIn,
  input wire logic [3:0] ioutFaultIn,
  input wire logic overTempIn,
  input wire logic frameCheckFail,
  input wire logic [3:0] channelStepping,
  output logic [3:0] slewLimitEnable,
  output logic [15:0] slewUpdateRate,
  output logic [11:0] slewIncrementSize,
  output logic statusEchoEnable,
  output logic rampActive,
  output logic faultAlarm
);
  // Link domain
  logic [4:0] bitCount_reg;
  logic [22:0] rxShift_reg;
  logic [23:0] rxWord_reg;
  logic rxToggle_reg;
  logic serialOut_reg;
  // Loaded by the system side well before the next frame opens
  logic [23:0] txWord_reg;
  wire [4:0] txIndex = 5'(`FRAME_LAST - bitCount_reg);
  wire inFrame = bitCount_reg != `FRAME_BITS;

  // Counter cleared by the frame's own select, so a stopped clock is harmless
  always_ff @(posedge linkClk or posedge frameSelectN) begin
    if (frameSelectN) begin
      bitCount_reg <= 5'h00;
    end else if (inFrame) begin
      bitCount_reg <= 5'(bitCount_reg + 5'h01);
    end
  end

  always_ff @(posedge linkClk) begin
    rxShift_reg <= {rxShift_reg[21:0], serialIn};
    if (!frameSelectN && bitCount_reg == `FRAME_LAST) begin
      rxWord_reg <= {rxShift_reg, serialIn};
    end
  end

  // Toggle marks a complete frame; short frames never reach it
  always_ff @(posedge linkClk or posedge srst) begin
    if (srst) begin
      rxToggle_reg <= 1'h0;
      serialOut_reg <= 1'h0;
    end else begin
      if (!frameSelectN && bitCount_reg == `FRAME_LAST) begin
        rxToggle_reg <= ~rxToggle_reg;
      end
      if (!frameSelectN && inFrame) begin
        serialOut_reg <= txWord_reg[txIndex];
      end
    end
  end

  assign serialOut = serialOut_reg;

  // System domain
  logic [14:0] pinSync;
  logic rxToggleSync;
  logic rxTogglePrev_reg;

  pin_sync #(.WIDTH(15)) pinSyncInst (
    .clk(clk),
    .srst(srst),
    .pinIn({deviceAddrHigh, deviceAddrLow, boostFaultIn, voutFaultIn, ioutFaultIn,
      overTempIn}),
    .pinOut(pinSync)
  );

  pin_sync #(.WIDTH(1)) toggleSyncInst (
    .clk(clk),
    .srst(srst),
    .pinIn(rxToggle_reg),
    .pinOut(rxToggleSync)
  );

  wire [1:0] ownAddr = pinSync[14:13];
  wire [3:0] boostSync = pinSync[12:9];
  wire [3:0] voutSync = pinSync[8:5];
  wire [3:0] ioutSync = pinSync[4:1];
  wire overTempSync = pinSync[0] ? 1'h1 : 1'h0;
  wire [3:0] ioutOnly = {ioutSync[3:1], 1'h0} | {3'h0, ioutSync[0]};

  // Frame word is stable for a whole frame after its toggle arrives
  wire frameTaken = rxToggleSync ^ rxTogglePrev_reg;
  wire isRead = rxWord_reg[`RW_BIT];
  wire [1:0] frameAddr = rxWord_reg[`ADDR_HI:`ADDR_LO];
  wire [4:0] frameSel = rxWord_reg[`SEL_HI:`SEL_LO];
  wire [15:0] frameData = rxWord_reg[15:0];
  wire addrMatch = frameAddr == ownAddr;
  wire isNop = (rxWord_reg & ~`NOP_ADDR_MASK) == `NOP_WORD;
  register_readback_status_pkg::frame_kind_type frameKind;
  assign frameKind = !addrMatch ? register_readback_status_pkg::FRAME_FOREIGN :
    isRead ? register_readback_status_pkg::FRAME_READ_OWN :
    register_readback_status_pkg::FRAME_WRITE;
  wire ownRead = frameTaken && frameKind == register_readback_status_pkg::FRAME_READ_OWN;
  wire ownWrite = frameTaken && frameKind == register_readback_status_pkg::FRAME_WRITE
    && !isNop;
  wire isSlewSel = frameSel >= `SEL_SLEW_A && frameSel <= `SEL_SLEW_D;
  wire storeWrite = ownWrite && frameSel <= `SEL_LAST && frameSel != `SEL_STATUS;
  wire [15:0] storeData = isSlewSel ? (frameData & `SLEW_KEEP_MASK) : frameData;

  register_readback_status_pkg::reg_word_type regFile_reg [`REG_COUNT];
  logic [4:0] readSel_reg;
  logic pendingRead_reg;
  logic loadTx_reg;
  logic userToggle_reg;
  logic packetCheckFailure_reg;
  logic rampActive_reg;
  logic faultAlarm_reg;

  wire [15:0] statusWord = {boostSync, userToggle_reg, packetCheckFailure_reg,
    rampActive_reg, overTempSync, voutSync, ioutOnly};
  // Status selector reads live state, never the stored slot
  wire [15:0] readValue = readSel_reg == `SEL_STATUS ? statusWord :
    readSel_reg <= `SEL_LAST ? regFile_reg[readSel_reg] : `REG_RESET;
  wire echoOn = regFile_reg[`SEL_MAIN][`STATUS_ECHO_BIT];
  wire [23:0] txWord_next = pendingRead_reg ?
    {`TX_PAD, ownAddr, readSel_reg, readValue} :
    echoOn ? {`TX_PAD, ownAddr, `SEL_STATUS, statusWord} : `TX_RESET;

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        regFile_reg[i] <= `REG_RESET;
      end
    end else if (storeWrite) begin
      regFile_reg[frameSel] <= storeData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rxTogglePrev_reg <= 1'h0;
      readSel_reg <= 5'h00;
      pendingRead_reg <= 1'h0;
      loadTx_reg <= 1'h0;
    end else begin
      rxTogglePrev_reg <= rxToggleSync;
      loadTx_reg <= frameTaken;
      if (frameTaken) begin
        pendingRead_reg <= ownRead;
      end
      if (ownRead) begin
        readSel_reg <= frameSel;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      txWord_reg <= `TX_RESET;
    end else if (loadTx_reg) begin
      txWord_reg <= txWord_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      userToggle_reg <= 1'h0;
      packetCheckFailure_reg <= 1'h0;
      rampActive_reg <= 1'h0;
      faultAlarm_reg <= 1'h0;
    end else begin
      if (ownWrite && frameSel == `SEL_SOFTWARE) begin
        userToggle_reg <= frameData[`USER_TOGGLE_CMD_BIT];
      end
      if (frameTaken) begin
        packetCheckFailure_reg <= frameCheckFail;
      end
      rampActive_reg <= |(channelStepping & slewLimitEnable);
      // Boost faults deliberately left out of the pin
      faultAlarm_reg <= |voutSync || |ioutSync || overTempSync;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : gSlew
      assign slewLimitEnable[ch] = regFile_reg[`SEL_SLEW_A + ch][`SLEW_EN_BIT];
      assign slewUpdateRate[ch*4 +: 4] =
        regFile_reg[`SEL_SLEW_A + ch][`SLEW_RATE_HI:`SLEW_RATE_LO];
      assign slewIncrementSize[ch*3 +: 3] = regFile_reg[`SEL_SLEW_A + ch][`SLEW_STEP_HI:0];
    end
  endgenerate

  assign statusEchoEnable = echoOn;
  assign rampActive = rampActive_reg;
  assign faultAlarm = faultAlarm_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_read_latch: assert property (
    ownRead |=> readSel_reg == $past(frameSel) && pendingRead_reg)
    else $error("read selector not latched");

  chk_foreign_hold: assert property (
    frameTaken && frameKind == register_readback_status_pkg::FRAME_FOREIGN
      |=> $stable(readSel_reg) && !pendingRead_reg)
    else $error("foreign read disturbed selection");

  chk_tx_readback: assert property (
    ownRead |=> ##1 txWord_reg[15:0] == $past(readValue) && txWord_reg[20:16] == readSel_reg)
    else $error("readback word not loaded");

  chk_status_slot: assert property (
    regFile_reg[`SEL_STATUS] == `REG_RESET)
    else $error("status slot written");

  chk_slew_zero: assert property (
    regFile_reg[`SEL_SLEW_A][15:13] == 3'h0 && regFile_reg[`SEL_SLEW_D][15:13] == 3'h0)
    else $error("slew reserved bits set");

  chk_status_echo: assert property (
    loadTx_reg && !pendingRead_reg && echoOn |=> txWord_reg[15:0] == $past(statusWord))
    else $error("status echo missing");

  chk_echo_off: assert property (
    loadTx_reg && !pendingRead_reg && !echoOn |=> txWord_reg == `TX_RESET)
    else $error("status sent without echo");

  chk_ramp_flag: assert property (
    (channelStepping & slewLimitEnable) != 4'h0 |=> rampActive ##1 (statusWord[9] == 1'h1
      || $past((channelStepping & slewLimitEnable) == 4'h0)))
    else $error("ramp flag not raised");

  chk_boost_pin: assert property (
    (voutSync == 4'h0 && ioutSync == 4'h0 && !overTempSync)[*2] |-> !faultAlarm)
    else $error("boost fault drove pin");

  chk_nop_ignored: assert property (
    frameTaken && isNop |=> $stable(readSel_reg) && !pendingRead_reg)
    else $error("nop changed state");

  chk_toggle_bit: assert property (
    ownWrite && frameSel == `SEL_SOFTWARE |=> ##1
      statusWord[11] == $past(frameData[`USER_TOGGLE_CMD_BIT], 2))
    else $error("user toggle not followed");

  cov_own_read: cover property (ownRead ##[1:200] ownRead);
  cov_echo: cover property (loadTx_reg && echoOn && !pendingRead_reg);
  cov_foreign: cover property (frameTaken && frameKind ==
    register_readback_status_pkg::FRAME_FOREIGN);
  cov_slew_write: cover property (storeWrite && isSlewSel);
endmodule // register_readback_status

// ===== sim/host_model.sv
// Host serial master model: sends 24-bit frames, captures device output.
// Assumes the device samples on link rising edges and drives after them.
`timescale 1ns/1ps
module host_model (
  output logic linkClk,
  output logic frameSelectN,
  output logic serialIn,
  input wire logic serialOut
);
  initial begin
    linkClk = 1'b0;
    frameSelectN = 1'b1;
    serialIn = 1'b0;
  end
  function automatic logic [23:0] nopWord(input logic [1:0] addr);
    return 24'h1CE000 | {1'b0, addr, 21'h000000};
  endfunction
  // Link clock stands still between frames
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    frameSelectN = 1'b0;
    for (int k = 23; k >= 0; k--) begin
      serialIn = tx[k];
      #7.5 linkClk = 1'b1;
      #7.5 linkClk = 1'b0;
      rx[k] = serialOut;
    end
    #7.5 frameSelectN = 1'b1;
    // Released line shows the inverse, never a stale level
    serialIn = ~tx[0];
    #100;
  endtask
endmodule // host_model

// ===== sim/register_readback_status_tb.sv
// Self-checking bench for the readback and status block.
// Assumes the host model above drives the link; own address is 1.
`timescale 1ns/1ps
module register_readback_status_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic linkClk, frameSelectN, serialIn, serialOut, echoEn, rampActive, faultAlarm;
  logic addrHigh = 1'b0;
  logic addrLow = 1'b1;
  logic [3:0] boostFault = 4'h0;
  logic [3:0] voutFault = 4'h0;
  logic [3:0] ioutFault = 4'h0;
  logic overTemp = 1'b0;
  logic checkFail = 1'b0;
  logic [3:0] stepping = 4'h0;
  logic [3:0] slewEn;
  logic [15:0] slewRate;
  logic [11:0] slewStep;
  logic [23:0] rx;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  host_model host_u (.linkClk(linkClk), .frameSelectN(frameSelectN), .serialIn(serialIn),
    .serialOut(serialOut));
  register_readback_status dut_u (.clk(clk), .srst(srst), .linkClk(linkClk),
    .frameSelectN(frameSelectN), .serialIn(serialIn), .serialOut(serialOut),
    .deviceAddrHigh(addrHigh), .deviceAddrLow(addrLow), .boostFaultIn(boostFault),
    .voutFaultIn(voutFault), .ioutFaultIn(ioutFault), .overTempIn(overTemp),
    .frameCheckFail(checkFail), .channelStepping(stepping), .slewLimitEnable(slewEn),
    .slewUpdateRate(slewRate), .slewIncrementSize(slewStep), .statusEchoEnable(echoEn),
    .rampActive(rampActive), .faultAlarm(faultAlarm));
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic cmp_word(input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t word exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic cmp_pins(input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t pins exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] sel, input logic [15:0] val);
    host_u.xfer({1'b0, 2'b01, sel, val}, rx);
  endtask
  task automatic rd(input logic [1:0] addr, input logic [4:0] sel);
    host_u.xfer({1'b1, addr, sel, 16'h0000}, rx);
  endtask
  task automatic nop();
    host_u.xfer(host_u.nopWord(2'b01), rx);
  endtask
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Loop pattern; slew words lose their reserved bits on write
  function automatic logic [23:0] expWord(input logic [4:0] sel);
    logic [15:0] v;
    v = {8'hC3, 3'h0, sel};
    if (sel >= 5'h14 && sel <= 5'h17) v = v & 16'h107F;
    return {3'b001, sel, v};
  endfunction
  initial begin
    waitClk(4);
    srst <= 1'b0;
    waitClk(4);
    cmp_pins(16'h0000, {slewEn, echoEn, rampActive, faultAlarm, 9'h000});
    $display("reset test done");
    for (int s = 0; s < 27; s++) if (s != 24) wr(5'(s), 16'(expWord(5'(s))));
    for (int s = 0; s <= 27; s++) begin
      if (s < 27) rd(2'b01, 5'(s));
      else nop();
      if (s > 0 && s != 25) cmp_word(expWord(5'(s - 1)), rx);
    end
    cmp_pins(16'h2222, slewRate);
    cmp_pins(16'h0FAC, {4'h0, slewStep});
    $display("selector test done");
    wr(5'h14, 16'hFFFF);
    rd(2'b01, 5'h14);
    host_u.xfer({1'b1, 2'b01, 5'h15, 16'hFFFF}, rx);
    cmp_word(24'h34107F, rx);
    nop();
    cmp_word(24'h350015, rx);
    cmp_pins(16'h12F7, {slewEn, slewRate[7:0], 1'b0, slewStep[2:0]});
    wr(5'h14, 16'h0000);
    host_u.xfer({1'b0, 2'b10, 5'h14, 16'hFFFF}, rx);
    rd(2'b01, 5'h14);
    rd(2'b10, 5'h14);
    cmp_word(24'h340000, rx);
    nop();
    cmp_word(24'h000000, rx);
    cmp_pins(16'h0200, {slewEn, slewRate[7:0], 1'b0, slewStep[2:0]});
    $display("slew test done");
    @(posedge clk) boostFault <= 4'hA;
    waitClk(10);
    cmp_pins(16'h0000, {15'h0000, faultAlarm});
    @(posedge clk) begin
      voutFault <= 4'h5;
      ioutFault <= 4'h3;
      overTemp <= 1'b1;
      stepping <= 4'h2;
      checkFail <= 1'b1;
    end
    waitClk(10);
    cmp_pins(16'h0001, {14'h0000, rampActive, faultAlarm});
    wr(5'h1B, 16'h1000);
    wr(5'h18, 16'h0000);
    wr(5'h14, 16'h1000);
    @(posedge clk) stepping <= 4'h1;
    waitClk(10);
    rd(2'b01, 5'h18);
    nop();
    cmp_word(24'h38AF53, rx);
    cmp_pins(16'h0003, {14'h0000, rampActive, faultAlarm});
    $display("status test done");
    wr(5'h19, 16'h0800);
    @(posedge clk) checkFail <= 1'b0;
    wr(5'h00, 16'h0001);
    nop();
    cmp_word(24'h38AB53, rx);
    cmp_pins(16'h0001, {15'h0000, echoEn});
    wr(5'h19, 16'h0000);
    wr(5'h00, 16'h0002);
    nop();
    cmp_word(24'h000000, rx);
    $display("echo test done");
    summarize();
  end
endmodule // register_readback_status_tb
